// ==== common/isbt_pkg.sv ====
// types shared by the special-register block
`default_nettype none
package isbt_pkg;
    // integer operations of the flag alu; all but compare and and touch the exception flags
    typedef enum logic [2:0] {
        ISBT_OP_ADD,
        ISBT_OP_ADDC,
        ISBT_OP_ADDE,
        ISBT_OP_SUBFC,
        ISBT_OP_SUBFE,
        ISBT_OP_SRA,
        ISBT_OP_CMP,
        ISBT_OP_AND
    } isbt_op_e;
    // state of the top block, apart from the time counter
    typedef struct packed {
        logic [31:0] integer_exception_flags;
        logic [31:0] lr;
        logic [31:0] ctr;
        logic [31:0] psw;
        logic [31:0] srr;
        logic [31:0] rdata;
        logic        ack;
        logic        fault;
        logic [31:0] result;
        logic        done;
        logic [3:0]  cr0;
    } isbt_state_s;
    // whole state of the time counter
    typedef struct packed {
        logic [63:0] count;
    } isbt_tb_s;
endpackage
`default_nettype wire

// ==== common/isbt_regs.svh ====
// register encodings, field positions and counts of the special registers
`ifndef ISBT_REGS_SVH
`define ISBT_REGS_SVH
// ----------------------------------------------------------------------
// special-register encodings (10-bit move field)
// ----------------------------------------------------------------------
`define ISBT_SPR_XER      10'h001
`define ISBT_SPR_LR       10'h008
`define ISBT_SPR_CTR      10'h009
`define ISBT_SPR_SRR      10'h01B
`define ISBT_SPR_TBL_RD   10'h10C
`define ISBT_SPR_TBU_RD   10'h10D
`define ISBT_SPR_TBL_WR   10'h11C
`define ISBT_SPR_TBU_WR   10'h11D
`define ISBT_SPR_PSW      10'h3FF
// ----------------------------------------------------------------------
// integer exception flags fields (bit 0 of the text is bit 31 here)
// ----------------------------------------------------------------------
`define ISBT_XER_SO       31
`define ISBT_XER_OV       30
`define ISBT_XER_CA       29
`define ISBT_XER_KEEP     32'hE000FF7F
`define ISBT_LR_ADDR_MASK 32'hFFFFFFFC
`define ISBT_INSN_BYTES   32'h00000004
// ----------------------------------------------------------------------
// processor state word fields
// ----------------------------------------------------------------------
`define ISBT_PSW_PR       14
`define ISBT_PSW_ILE      16
`define ISBT_PSW_LE       0
`define ISBT_PSW_RESET    32'h00000000
`define ISBT_PSW_EXC_KEEP 32'h000110C0
`define ISBT_TB_WIDTH     64
`endif

// ==== design/isbt_flag_alu.sv ====
// integer adder and shifter that derives carry and signed wrap flags
`timescale 1ns/1ps
`default_nettype none
module isbt_flag_alu (
    input  wire logic             [2:0]  op_i,      // isbt_op_e code
    input  wire logic             [31:0] a_i,       // first operand
    input  wire logic             [31:0] b_i,       // second operand
    input  wire logic                    ca_i,      // carry in from flags
    input  wire logic             [4:0]  sh_i,      // shift amount
    output logic                  [31:0] res_o,     // full result
    output logic                         ca_o,      // carry flag value
    output logic                         ov_o,      // signed wrap value
    output logic                         ca_we_o,   // op may alter carry
    output logic                         ov_we_o    // op may overflow
);
    // ------------------------------------------------------------------
    // one full sum over the whole operation, plus a 31-bit low sum for the wrap flag
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] x;
        logic        cin;
        logic [32:0] sum;
        logic [31:0] low;
        logic [31:0] lost;
        x       = a_i;
        cin     = 1'b0;
        ca_we_o = 1'b0;
        ov_we_o = 1'b0;
        case (isbt_pkg::isbt_op_e'(op_i))
            isbt_pkg::ISBT_OP_ADD: begin
                ov_we_o = 1'b1;
            end
            isbt_pkg::ISBT_OP_ADDC: begin
                ov_we_o = 1'b1;
                ca_we_o = 1'b1;
            end
            isbt_pkg::ISBT_OP_ADDE: begin
                cin     = ca_i;
                ov_we_o = 1'b1;
                ca_we_o = 1'b1;
            end
            isbt_pkg::ISBT_OP_SUBFC: begin
                x       = ~a_i;
                cin     = 1'b1;
                ov_we_o = 1'b1;
                ca_we_o = 1'b1;
            end
            isbt_pkg::ISBT_OP_SUBFE: begin
                x       = ~a_i;
                cin     = ca_i;
                ov_we_o = 1'b1;
                ca_we_o = 1'b1;
            end
            isbt_pkg::ISBT_OP_SRA: begin
                ca_we_o = 1'b1;
            end
            default: begin
                ca_we_o = 1'b0;                           // compares leave flags
            end
        endcase
        sum  = {1'b0, x} + {1'b0, b_i} + {32'h00000000, cin};
        low  = {1'b0, x[30:0]} + {1'b0, b_i[30:0]} + {31'h00000000, cin};
        lost = a_i & ~(32'hFFFFFFFF << sh_i);
        ov_o = low[31] ^ sum[32];
        case (isbt_pkg::isbt_op_e'(op_i))
            isbt_pkg::ISBT_OP_SRA: begin
                res_o = $unsigned($signed(a_i) >>> sh_i);
                ca_o  = a_i[31] & (|lost);
            end
            isbt_pkg::ISBT_OP_CMP: begin
                res_o = sum[31:0];
                ca_o  = 1'b0;
            end
            isbt_pkg::ISBT_OP_AND: begin
                res_o = a_i & b_i;
                ca_o  = 1'b0;
            end
            default: begin
                res_o = sum[31:0];
                ca_o  = sum[32];
            end
        endcase
    end
endmodule // isbt_flag_alu
`default_nettype wire

// ==== design/isbt_spr_core.sv ====
// integer exception flags, link, loop count, time counter and state word
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "isbt_regs.svh"
module isbt_spr_core (
    input  wire logic        clock_i,        // core clock
    input  wire logic        rst_n_i,        // sync reset, active low
    // special-register moves
    input  wire logic        spr_rd_i,       // move-from request
    input  wire logic        spr_wr_i,       // move-to request
    input  wire logic [9:0]  spr_addr_i,     // register encoding
    input  wire logic [31:0] spr_wdata_i,    // move-to data
    output logic      [31:0] spr_rdata_o,    // move-from data
    output logic             spr_ack_o,      // move accepted pulse
    output logic             spr_fault_o,    // move refused pulse
    // integer unit
    input  wire logic        alu_valid_i,    // operation completes
    input  wire logic [2:0]  alu_op_i,       // isbt_op_e code
    input  wire logic        alu_oe_i,       // overflow enable option
    input  wire logic        alu_rc_i,       // record in condition field
    input  wire logic [31:0] alu_a_i,        // first operand
    input  wire logic [31:0] alu_b_i,        // second operand
    input  wire logic [4:0]  alu_sh_i,       // shift amount
    output logic      [31:0] alu_result_o,   // registered result
    output logic             alu_done_o,     // result valid pulse
    output logic      [3:0]  cond_field_o,   // lt gt eq so
    // branch unit
    input  wire logic        br_valid_i,     // branch completes
    input  wire logic        br_link_i,      // link option
    input  wire logic        br_dec_i,       // decrement loop count
    input  wire logic [31:0] br_pc_i,        // address of the branch
    output logic      [31:0] return_target_o, // link return target
    output logic      [31:0] count_target_o, // count register target
    output logic      [6:0]  string_bytes_o, // string move byte count
    // exceptions
    input  wire logic        exc_i,          // exception taken
    input  wire logic        system_call_i,  // system call executed
    input  wire logic        rfi_i,          // return from exception
    input  wire logic        time_tick_i,    // time counter tick
    output logic      [31:0] psw_o           // processor state word
);
    isbt_pkg::isbt_state_s state_reg;  // registered state
    isbt_pkg::isbt_state_s state_next; // next state
    logic [31:0] tb_hi;                // upper time half
    logic [31:0] tb_lo;                // lower time half
    logic [31:0] alu_res;              // alu result
    logic        alu_ca;               // alu carry
    logic        alu_ov;               // alu wrap
    logic        alu_ca_we;            // carry update enable
    logic        alu_ov_we;            // wrap update enable
    logic        user_mode;            // problem state
    logic        tb_wr_hi;             // time upper load
    logic        tb_wr_lo;             // time lower load
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    assign user_mode = state_reg.psw[`ISBT_PSW_PR];
    assign tb_wr_hi  = spr_wr_i && !user_mode && spr_addr_i == `ISBT_SPR_TBU_WR;
    assign tb_wr_lo  = spr_wr_i && !user_mode && spr_addr_i == `ISBT_SPR_TBL_WR;
    // flag computation
    isbt_flag_alu isbt_flag_alu_inst (
        .op_i    (alu_op_i),
        .a_i     (alu_a_i),
        .b_i     (alu_b_i),
        .ca_i    (state_reg.integer_exception_flags[`ISBT_XER_CA]),
        .sh_i    (alu_sh_i),
        .res_o   (alu_res),
        .ca_o    (alu_ca),
        .ov_o    (alu_ov),
        .ca_we_o (alu_ca_we),
        .ov_we_o (alu_ov_we)
    );
    // time counter
    isbt_time_count #(
        .WIDTH (`ISBT_TB_WIDTH)
    ) isbt_time_count_inst (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_i  (time_tick_i),
        .wr_hi_i (tb_wr_hi),
        .wr_lo_i (tb_wr_lo),
        .wdata_i (spr_wdata_i),
        .upper_o (tb_hi),
        .lower_o (tb_lo)
    );
    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic ok;
        logic [31:0] rd;
        state_next       = state_reg;
        state_next.ack   = 1'b0;
        state_next.fault = 1'b0;
        state_next.done  = 1'b0;
        ok = 1'b0;
        rd = 32'h00000000;
        // move decode for reads and writes; each time half has its own read and write encoding
        case (spr_addr_i)
            `ISBT_SPR_XER: begin
                ok = 1'b1;
                rd = state_reg.integer_exception_flags & `ISBT_XER_KEEP;
            end
            `ISBT_SPR_LR: begin
                ok = 1'b1;
                rd = state_reg.lr;
            end
            `ISBT_SPR_CTR: begin
                ok = 1'b1;
                rd = state_reg.ctr;
            end
            `ISBT_SPR_TBL_RD: begin
                ok = spr_rd_i;
                rd = tb_lo;
            end
            `ISBT_SPR_TBU_RD: begin
                ok = spr_rd_i;
                rd = tb_hi;
            end
            `ISBT_SPR_TBL_WR, `ISBT_SPR_TBU_WR: begin
                ok = spr_wr_i && !user_mode;
            end
            `ISBT_SPR_SRR: begin
                ok = !user_mode;
                rd = state_reg.srr;
            end
            `ISBT_SPR_PSW: begin
                ok = !user_mode;
                rd = state_reg.psw;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        // move answer
        if (spr_rd_i || spr_wr_i) begin
            state_next.ack   = ok;
            state_next.fault = !ok;
            if (spr_rd_i && ok) begin
                state_next.rdata = rd;
            end
        end
        // move-to writes
        if (spr_wr_i && ok) begin
            case (spr_addr_i)
                `ISBT_SPR_XER: begin
                    state_next.integer_exception_flags = spr_wdata_i & `ISBT_XER_KEEP;
                end
                `ISBT_SPR_LR: begin
                    state_next.lr = spr_wdata_i;
                end
                `ISBT_SPR_CTR: begin
                    state_next.ctr = spr_wdata_i;
                end
                `ISBT_SPR_SRR: begin
                    state_next.srr = spr_wdata_i;
                end
                `ISBT_SPR_PSW: begin
                    state_next.psw = spr_wdata_i;
                end
                default: begin
                    state_next.psw = state_next.psw;      // time halves load in isbt_time_count
                end
            endcase
        end
        // integer unit flags override a same-cycle flag write, so the unit's value wins
        if (alu_valid_i) begin
            state_next.result = alu_res;
            state_next.done   = 1'b1;
            if (alu_ca_we) begin
                state_next.integer_exception_flags[`ISBT_XER_CA] = alu_ca;
            end
            if (alu_ov_we && alu_oe_i) begin
                state_next.integer_exception_flags[`ISBT_XER_OV] = alu_ov;
                if (alu_ov) begin
                    state_next.integer_exception_flags[`ISBT_XER_SO] = 1'b1;
                end
            end
            if (alu_rc_i) begin
                state_next.cr0 = {$signed(alu_res) < 0,
                                  $signed(alu_res) > 0,
                                  alu_res == 32'h00000000,
                                  state_next.integer_exception_flags[`ISBT_XER_SO]};
            end
        end
        // branch unit
        if (br_valid_i) begin
            if (br_link_i) begin
                state_next.lr = br_pc_i + `ISBT_INSN_BYTES;
            end
            if (br_dec_i) begin
                state_next.ctr = state_reg.ctr - 32'h00000001;
            end
        end
        // exception entry, system call and return
        if (exc_i || system_call_i) begin
            state_next.srr = state_reg.psw;
            state_next.psw = state_reg.psw & `ISBT_PSW_EXC_KEEP;
            state_next.psw[`ISBT_PSW_LE] = state_reg.psw[`ISBT_PSW_ILE];
        end else if (rfi_i) begin
            state_next.psw = state_reg.srr;
        end
        // reset clears control outputs, read data, the condition field and the state word, leaves the other architected registers
        if (!rst_n_i) begin
            state_next.psw   = `ISBT_PSW_RESET;
            state_next.ack   = 1'b0;
            state_next.fault = 1'b0;
            state_next.done  = 1'b0;
            state_next.rdata = 32'h00000000;
            state_next.cr0   = 4'h0;
            // reserved flag bits read zero anyway, so clearing them keeps
            // the visible value while removing unknowns from storage
            state_next.integer_exception_flags   = state_reg.integer_exception_flags & `ISBT_XER_KEEP;
        end
    end
    // state register
    always_ff @(posedge clock_i) begin
        state_reg <= state_next;
    end
    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign spr_rdata_o    = state_reg.rdata;
    assign spr_ack_o      = state_reg.ack;
    assign spr_fault_o    = state_reg.fault;
    assign alu_result_o   = state_reg.result;
    assign alu_done_o     = state_reg.done;
    assign cond_field_o   = state_reg.cr0;
    assign return_target_o = state_reg.lr & `ISBT_LR_ADDR_MASK;
    assign count_target_o = state_reg.ctr;
    assign string_bytes_o = state_reg.integer_exception_flags[6:0];
    assign psw_o          = state_reg.psw;
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    AST_SO_STICKY: assert property (
        state_reg.integer_exception_flags[31] && !(spr_wr_i && spr_addr_i == `ISBT_SPR_XER) |=> state_reg.integer_exception_flags[31])
        else $error("summary overflow dropped without a write");
    AST_SO_SET: assert property (
        alu_valid_i && alu_oe_i && alu_op_i == 3'h0 && alu_a_i == 32'h7FFFFFFF
        && alu_b_i == 32'h00000001 |=> state_reg.integer_exception_flags[31:30] == 2'b11)
        else $error("signed wrap did not set both overflow flags");
    AST_CA_ADD: assert property (
        alu_valid_i && alu_op_i == 3'h1 && alu_a_i == 32'hFFFFFFFF && alu_b_i == 32'h00000001
        |=> state_reg.integer_exception_flags[29] && alu_result_o == 32'h00000000)
        else $error("carry out not recorded");
    AST_CMP_KEEP: assert property (
        alu_valid_i && alu_op_i == 3'h6 && !spr_wr_i |=> $stable(state_reg.integer_exception_flags[31:29]))
        else $error("compare altered the flags");
    AST_RSV_ZERO: assert property (
        state_reg.integer_exception_flags[28:16] == 13'h0000 && !state_reg.integer_exception_flags[7])
        else $error("reserved flag bits not zero");
    AST_LINK: assert property (
        br_valid_i && br_link_i |=> state_reg.lr == $past(br_pc_i) + 32'h00000004)
        else $error("link register not loaded with next address");
    AST_CTR_WRAP: assert property (
        br_valid_i && br_dec_i && state_reg.ctr == 32'h00000000 |=> count_target_o == 32'hFFFFFFFF)
        else $error("loop count did not wrap to all ones");
    AST_TB_PRIV: assert property (
        spr_wr_i && user_mode
        && (spr_addr_i == `ISBT_SPR_TBL_WR || spr_addr_i == `ISBT_SPR_TBU_WR)
        |=> spr_fault_o ##1 !spr_fault_o)
        else $error("user time write not refused");
    AST_EXC_SAVE: assert property (
        exc_i |=> state_reg.srr == $past(state_reg.psw) && !psw_o[14])
        else $error("state word not saved on exception");
    AST_CR0_SO: assert property (
        alu_valid_i && alu_rc_i |=> cond_field_o[0] == state_reg.integer_exception_flags[31])
        else $error("condition field summary bit mismatch");
endmodule // isbt_spr_core
`default_nettype wire

// ==== design/isbt_time_count.sv ====
// free running time counter split into upper and lower halves
`timescale 1ns/1ps
`default_nettype none
`include "isbt_regs.svh"
module isbt_time_count #(
    parameter int WIDTH = `ISBT_TB_WIDTH                   // counter width
) (
    input  wire logic               clock_i,    // core clock
    input  wire logic               rst_n_i,    // sync reset, count kept
    input  wire logic               tick_i,     // one-cycle count pulse
    input  wire logic               wr_hi_i,    // load upper half
    input  wire logic               wr_lo_i,    // load lower half
    input  wire logic [31:0]        wdata_i,    // load value
    output logic      [31:0]        upper_o,    // most significant half
    output logic      [31:0]        lower_o     // least significant half
);
    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (WIDTH != 64) begin : g_bad_width
        $error("time counter must be 64 bits");
    end
    isbt_pkg::isbt_tb_s state_reg;   // registered state
    isbt_pkg::isbt_tb_s state_next;  // next state
    // ------------------------------------------------------------------
    // count and load; a load wins over a tick for its half
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (tick_i) begin
            state_next.count = state_reg.count + 64'h0000000000000001;
        end
        if (wr_hi_i) begin
            state_next.count[63:32] = wdata_i;
        end
        if (wr_lo_i) begin
            state_next.count[31:0] = wdata_i;
        end
    end
    // register, left as it is through reset
    always_ff @(posedge clock_i) begin
        state_reg <= state_next;
    end
    assign upper_o = state_reg.count[63:32];
    assign lower_o = state_reg.count[31:0];
    AST_TB_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tick_i && !wr_hi_i && !wr_lo_i |=> state_reg.count == $past(state_reg.count) + 64'h1)
        else $error("time counter did not step on tick");
    AST_TB_LOAD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_lo_i |=> lower_o == $past(wdata_i))
        else $error("lower half load not seen next cycle");
endmodule // isbt_time_count
`default_nettype wire

// ==== tb/isbt_spr_core_tb_top.sv ====
// self-checking bench of the special-register block
`timescale 1ns/1ps
`default_nettype none
`include "isbt_regs.svh"
module isbt_spr_core_tb_top;
    logic        clock_i = 1'h0, rst_n_i = 1'h0, rd = 1'h0, wr = 1'h0;
    logic        av = 1'h0, oe = 1'h1, rc = 1'h1, bv = 1'h0, bl = 1'h0, bd = 1'h0, tick = 1'h0;
    logic [2:0]  ev = 3'h0, aop = 3'h0;   // exception, system call, return
    logic [4:0]  sh = 5'h0;
    logic [9:0]  addr = 10'h0;
    logic [31:0] wd = 32'h0, aa = 32'h0, ab = 32'h0, pc = 32'h0;
    logic [31:0] rdata, res, lrt, ctrt, psw;
    logic        ack, fault, done;
    logic [3:0]  cr0;
    logic [6:0]  sb;
    int          fails = 0, total_checks = 0;
    isbt_spr_core isbt_spr_core_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .spr_rd_i(rd),
        .spr_wr_i(wr), .spr_addr_i(addr), .spr_wdata_i(wd), .spr_rdata_o(rdata),
        .spr_ack_o(ack), .spr_fault_o(fault), .alu_valid_i(av), .alu_op_i(aop),
        .alu_oe_i(oe), .alu_rc_i(rc), .alu_a_i(aa), .alu_b_i(ab), .alu_sh_i(sh),
        .alu_result_o(res), .alu_done_o(done), .cond_field_o(cr0), .br_valid_i(bv),
        .br_link_i(bl), .br_dec_i(bd), .br_pc_i(pc), .return_target_o(lrt),
        .count_target_o(ctrt), .string_bytes_o(sb), .exc_i(ev[2]), .system_call_i(ev[1]),
        .rfi_i(ev[0]), .time_tick_i(tick), .psw_o(psw));
    // 100 MHz core clock
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // one register move; d is write data or expected read data
    task automatic mv(input logic r, input logic [9:0] a, input logic [31:0] d, input logic f);
        @(posedge clock_i);
        rd <= r;
        wr <= ~r;
        addr <= a;
        wd <= d;
        @(posedge clock_i);
        rd <= 1'h0;
        wr <= 1'h0;
        #1;
        chk("ack", {31'h0, ~f}, {31'h0, ack});
        chk("fault", {31'h0, f}, {31'h0, fault});
        if (r && !f) chk("rdata", d, rdata);
    endtask
    task automatic op(input logic [2:0] o, input logic [31:0] a, input logic [31:0] b,
                      input logic [4:0] s, input logic [31:0] e);
        @(posedge clock_i);
        av <= 1'h1;
        aop <= o;
        aa <= a;
        ab <= b;
        sh <= s;
        @(posedge clock_i);
        av <= 1'h0;
        #1;
        chk("done", 32'h1, {31'h0, done});
        chk("result", e, res);
    endtask
    // one-cycle pulse on a control input; lk/dc/p feed the branch unit
    task automatic pulse(input logic b, input logic [2:0] v, input logic lk, input logic dc,
                         input logic [31:0] p);
        @(posedge clock_i);
        bv <= b;
        ev <= v;
        bl <= lk;
        bd <= dc;
        pc <= p;
        tick <= ~b & (v == 3'h0);
        @(posedge clock_i);
        bv <= 1'h0;
        ev <= 3'h0;
        tick <= 1'h0;
        #1;
    endtask
    task automatic t_flags;
        mv(0, `ISBT_SPR_XER, 32'hFFFFFFFF, 0);
        mv(1, `ISBT_SPR_XER, 32'hE000FF7F, 0);
        chk("bytes", 32'h7F, {25'h0, sb});
        mv(0, `ISBT_SPR_XER, 32'h0, 0);
        op(isbt_pkg::ISBT_OP_ADD, 32'h7FFFFFFF, 32'h1, 5'h0, 32'h80000000);
        chk("cr0", 32'h9, {28'h0, cr0});
        op(isbt_pkg::ISBT_OP_ADD, 32'h1, 32'h1, 5'h0, 32'h2);
        op(isbt_pkg::ISBT_OP_CMP, 32'hFFFFFFFF, 32'h1, 5'h0, 32'h0);
        mv(1, `ISBT_SPR_XER, 32'h80000000, 0);
        op(isbt_pkg::ISBT_OP_ADDC, 32'hFFFFFFFF, 32'h1, 5'h0, 32'h0);
        mv(1, `ISBT_SPR_XER, 32'hA0000000, 0);
        op(isbt_pkg::ISBT_OP_SRA, 32'h80000001, 32'h0, 5'h1, 32'hC0000000);
        op(isbt_pkg::ISBT_OP_SUBFE, 32'h0, 32'h0, 5'h0, 32'h0);
        mv(1, `ISBT_SPR_XER, 32'hA0000000, 0);
        op(isbt_pkg::ISBT_OP_SRA, 32'h80000000, 32'h0, 5'h1, 32'hC0000000);
        mv(1, `ISBT_SPR_XER, 32'h80000000, 0);
        $display("test flags finished");
    endtask
    task automatic t_branch_time;
        mv(0, `ISBT_SPR_CTR, 32'h0, 0);
        pulse(1, 3'h0, 0, 1, 32'h0);
        chk("count", 32'hFFFFFFFF, ctrt);
        mv(0, `ISBT_SPR_LR, 32'h7, 0);
        mv(1, `ISBT_SPR_LR, 32'h7, 0);
        chk("link", 32'h4, lrt);
        pulse(1, 3'h0, 1, 0, 32'h100);
        chk("link", 32'h104, lrt);
        mv(0, `ISBT_SPR_TBL_WR, 32'hFFFFFFFF, 0);
        mv(0, `ISBT_SPR_TBU_WR, 32'h1, 0);
        pulse(0, 3'h0, 0, 0, 32'h0);
        mv(1, `ISBT_SPR_TBL_RD, 32'h0, 0);
        mv(1, `ISBT_SPR_TBU_RD, 32'h2, 0);
        mv(1, `ISBT_SPR_TBL_WR, 32'h0, 1);
        $display("test branch and time finished");
    endtask
    task automatic t_state;
        mv(0, `ISBT_SPR_PSW, 32'h4000, 0);
        pulse(0, 3'h4, 0, 0, 32'h0);
        chk("state", 32'h0, psw);
        mv(1, `ISBT_SPR_SRR, 32'h4000, 0);
        pulse(0, 3'h1, 0, 0, 32'h0);
        chk("state", 32'h4000, psw);
        mv(0, `ISBT_SPR_TBU_WR, 32'h5, 1);
        mv(1, `ISBT_SPR_PSW, 32'h0, 1);
        pulse(0, 3'h2, 0, 0, 32'h0);
        chk("state", 32'h0, psw);
        $display("test state finished");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // cut a hang short well past the expected run
    initial begin
        #20000;
        fails++;
        results;
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'h1;
        t_flags;
        t_branch_time;
        t_state;
        results;
    end
endmodule // isbt_spr_core_tb_top
`default_nettype wire
